// [hw/mpwd_matcher.sv]
// byte-stream magic packet pattern matcher
`timescale 1ns/1ps
module mpwd_matcher (
  input wire logic clk_i,
  input wire logic rst_i,
  mpwd_if.match m
);
  import mpwd_pkg::*;

  mpwd_state_t state_r;
  logic [2:0] hdr_cnt_r;
  logic [2:0] idx_r;
  logic [3:0] rep_cnt_r;
  logic st_ok_r;
  logic bc_ok_r;
  logic hit_r;
  logic pw_on;
  logic addr_ok;

  always_comb begin
    pw_on = 1'b0;
    for (int i = 0; i < MPWD_FIELD_LEN; i++) begin
      pw_on = pw_on | (m.pwd[i] != 8'h00);
    end
  end

  assign addr_ok = (st_ok_r && m.data == m.addr[idx_r]) || (bc_ok_r && m.data == MPWD_ONES);
  assign m.hit = hit_r;

  // ------------------------------------------------------------
  // search sequence
  // ------------------------------------------------------------
  // scans raw bytes, any protocol
  always_ff @(posedge clk_i) begin
    hit_r <= 1'b0;
    if (rst_i || !m.enable || !m.frame) begin
      state_r <= MPWD_ST_HUNT;
      hdr_cnt_r <= 3'h0;
      idx_r <= 3'h0;
      rep_cnt_r <= 4'h0;
      st_ok_r <= 1'b1;
      bc_ok_r <= 1'b1;
    end else if (m.valid) begin
      unique case (state_r)
        MPWD_ST_HUNT: begin
          if (m.data != MPWD_ONES) begin
            hdr_cnt_r <= 3'h0;
          end else if (hdr_cnt_r == MPWD_LAST_IDX) begin
            state_r <= MPWD_ST_ADDR;
            idx_r <= 3'h0;
            rep_cnt_r <= 4'h0;
            st_ok_r <= 1'b1;
            bc_ok_r <= 1'b1;
          end else begin
            hdr_cnt_r <= hdr_cnt_r + 3'h1;
          end
        end
        MPWD_ST_ADDR: begin
          if (!addr_ok) begin
            state_r <= MPWD_ST_HUNT;
            hdr_cnt_r <= (m.data == MPWD_ONES) ? 3'h1 : 3'h0;
          end else if (idx_r == MPWD_LAST_IDX) begin
            idx_r <= 3'h0;
            st_ok_r <= 1'b1;
            bc_ok_r <= 1'b1;
            if (rep_cnt_r == MPWD_LAST_REP) begin
              state_r <= pw_on ? MPWD_ST_PWD : MPWD_ST_HUNT;
              hit_r <= !pw_on;
              hdr_cnt_r <= 3'h0;
            end else begin
              rep_cnt_r <= rep_cnt_r + 4'h1;
            end
          end else begin
            idx_r <= idx_r + 3'h1;
            st_ok_r <= st_ok_r && m.data == m.addr[idx_r];
            bc_ok_r <= bc_ok_r && m.data == MPWD_ONES;
          end
        end
        MPWD_ST_PWD: begin
          if (m.data != m.pwd[idx_r]) begin
            state_r <= MPWD_ST_HUNT;
            hdr_cnt_r <= (m.data == MPWD_ONES) ? 3'h1 : 3'h0;
          end else if (idx_r == MPWD_LAST_IDX) begin
            state_r <= MPWD_ST_HUNT;
            hdr_cnt_r <= 3'h0;
            hit_r <= 1'b1;
          end else begin
            idx_r <= idx_r + 3'h1;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_hdr_enters_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    m.enable && m.frame && m.valid && state_r == MPWD_ST_HUNT && m.data == MPWD_ONES && hdr_cnt_r == 3'h5
    |=> state_r == MPWD_ST_ADDR) else $error("header did not open address field");
  a_hit_after_reps: assert property (@(posedge clk_i) disable iff (rst_i)
    hit_r |-> $past(rep_cnt_r == 4'hf && idx_r == 3'h5 && !pw_on) || $past(state_r == MPWD_ST_PWD && idx_r == 3'h5))
    else $error("hit without full sequence");
  a_zero_pwd_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == MPWD_ST_PWD && $stable(pw_on) |-> pw_on) else $error("password phase with zero password");
  a_frame_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    !m.frame |=> state_r == MPWD_ST_HUNT && hdr_cnt_r == 3'h0) else $error("search not restarted");
  c_pwd_phase: cover property (@(posedge clk_i) state_r == MPWD_ST_PWD);

endmodule : mpwd_matcher

// [hw/mpwd_top.sv]
// magic packet wake detector with wishbone register file
`timescale 1ns/1ps

// Summary of operation
// - a wake packet opens with six consecutive 0xff bytes in the frame
// - then the station address must follow sixteen times back to back
// - any copy may be the broadcast address instead of the station address
// - with a password set, the next six bytes must equal it to match
// - an all-zero password means no password is checked
// - a match raises the management interrupt output to wake the host
// - detection works at 10, 100 and 1000 Mbit/s link speeds
// - the pattern is found anywhere in the frame, whatever the protocol, except directly after another 0xff byte
// - station address sits in six byte registers, index 0 first on wire
// - password sits in six byte registers, index 0 first byte
// - wake reaches the interrupt only while its mask bit is one
// - detection runs only while the enable bit is one, set by host after address and mask

module mpwd_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // received byte stream
  input wire logic rx_frame_i,
  input wire logic rx_valid_i,
  input wire mpwd_pkg::mpwd_byte_t rx_data_i,
  // wake notification
  output logic mgmt_interrupt_out_o
);
  import mpwd_pkg::*;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // returns 1 when adr falls in the six-word block at base
  function automatic logic in_block(input logic [7:0] adr, input logic [7:0] base);
    logic [7:0] d;
    d = adr - base;
    in_block = (adr >= base) && (d[7:2] < 6'(MPWD_FIELD_LEN)) && (d[1:0] == 2'h0);
  endfunction : in_block

  // word index within a block
  function automatic logic [2:0] blk_idx(input logic [7:0] adr, input logic [7:0] base);
    logic [7:0] d;
    d = adr - base;
    blk_idx = d[4:2];
  endfunction : blk_idx

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic wake_detect_enable_r;
  logic wake_interrupt_mask_r;
  logic wake_stat_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic irq_r;
  mpwd_byte_t wake_station_addr_r [MPWD_FIELD_LEN];
  mpwd_byte_t wake_password_r [MPWD_FIELD_LEN];

  logic req;
  logic wr_acc;
  logic wr_lane0;
  logic clr_wake;
  logic [31:0] rd_nxt;

  mpwd_if link ();

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // ack one cycle after the request; it drops the cycle after, so a
  // held request is never answered on two cycles in a row
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  // writes land on the ack edge, where the master sees its cycle end
  assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign wr_lane0 = wr_acc && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_detect_enable_r <= MPWD_RST_ENABLE;
    end else if (wr_lane0 && wb_adr_i == MPWD_OFS_CTRL) begin
      wake_detect_enable_r <= wb_dat_i[MPWD_BIT_ENABLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_interrupt_mask_r <= MPWD_RST_MASK;
    end else if (wr_lane0 && wb_adr_i == MPWD_OFS_MASK) begin
      wake_interrupt_mask_r <= wb_dat_i[MPWD_BIT_MASK];
    end
  end

  // ------------------------------------------------------------
  // address and password bytes
  // ------------------------------------------------------------
  // station address byte registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < MPWD_FIELD_LEN; i++) begin
        wake_station_addr_r[i] <= MPWD_RST_BYTE;
      end
    end else if (wr_lane0 && in_block(wb_adr_i, MPWD_OFS_ADDR0)) begin
      wake_station_addr_r[blk_idx(wb_adr_i, MPWD_OFS_ADDR0)] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < MPWD_FIELD_LEN; i++) begin
        wake_password_r[i] <= MPWD_RST_BYTE;
      end
    end else if (wr_lane0 && in_block(wb_adr_i, MPWD_OFS_PWD0)) begin
      wake_password_r[blk_idx(wb_adr_i, MPWD_OFS_PWD0)] <= wb_dat_i[7:0];
    end
  end

  // ------------------------------------------------------------
  // wake status and interrupt
  // ------------------------------------------------------------
  // write one clears; a hit in the same cycle wins so no wake is lost
  assign clr_wake = wr_lane0 && wb_adr_i == MPWD_OFS_STAT && wb_dat_i[MPWD_BIT_WAKE];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_stat_r <= MPWD_RST_STAT;
    end else if (link.hit) begin
      wake_stat_r <= 1'b1;
    end else if (clr_wake) begin
      wake_stat_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= wake_stat_r && wake_interrupt_mask_r;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // unmapped offsets read as zero and are still acknowledged
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i == MPWD_OFS_CTRL) begin
      rd_nxt[MPWD_BIT_ENABLE] = wake_detect_enable_r;
    end else if (wb_adr_i == MPWD_OFS_MASK) begin
      rd_nxt[MPWD_BIT_MASK] = wake_interrupt_mask_r;
    end else if (wb_adr_i == MPWD_OFS_STAT) begin
      rd_nxt[MPWD_BIT_WAKE] = wake_stat_r;
    end else if (in_block(wb_adr_i, MPWD_OFS_ADDR0)) begin
      rd_nxt[7:0] = wake_station_addr_r[blk_idx(wb_adr_i, MPWD_OFS_ADDR0)];
    end else if (in_block(wb_adr_i, MPWD_OFS_PWD0)) begin
      rd_nxt[7:0] = wake_password_r[blk_idx(wb_adr_i, MPWD_OFS_PWD0)];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      dat_r <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign mgmt_interrupt_out_o = irq_r;

  // ------------------------------------------------------------
  // matcher hookup
  // ------------------------------------------------------------
  // byte strobe covers all link speeds
  // the strobe rate sets the speed; the matcher needs no speed setting
  assign link.enable = wake_detect_enable_r;
  assign link.frame = rx_frame_i;
  assign link.valid = rx_valid_i;
  assign link.data = rx_data_i;
  always_comb begin
    for (int i = 0; i < MPWD_FIELD_LEN; i++) begin
      link.addr[i] = wake_station_addr_r[i];
      link.pwd[i] = wake_password_r[i];
    end
  end

  mpwd_matcher u_matcher (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .m (link.match)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  a_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not one cycle after request");

  a_hit_sets_stat: assert property (@(posedge clk_i) disable iff (rst_i)
    link.hit |=> wake_stat_r ##1 (mgmt_interrupt_out_o == wake_interrupt_mask_r || $changed(wake_interrupt_mask_r)))
    else $error("wake hit not reported");

  a_set_beats_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    link.hit && clr_wake |=> wake_stat_r) else $error("clear beat a new wake");

  a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    !wake_interrupt_mask_r [*2] |-> !mgmt_interrupt_out_o) else $error("interrupt while masked");

  a_irq_source: assert property (@(posedge clk_i) disable iff (rst_i)
    mgmt_interrupt_out_o |-> $past(wake_stat_r) && $past(wake_interrupt_mask_r))
    else $error("interrupt without masked-in wake");

  a_enable_gates: assert property (@(posedge clk_i) disable iff (rst_i)
    !wake_detect_enable_r |=> !link.hit) else $error("hit while detection disabled");

  a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && wb_adr_i == MPWD_OFS_CTRL |=> wake_detect_enable_r == $past(wb_dat_i[0]))
    else $error("enable write lost");

  a_addr_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && wb_adr_i == 8'h24 |=> wake_station_addr_r[5] == $past(wb_dat_i[7:0]))
    else $error("address byte five write lost");

  a_pwd_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_lane0 && wb_adr_i == 8'h28 |=> wake_password_r[0] == $past(wb_dat_i[7:0]))
    else $error("password byte zero write lost");

  c_wake_irq: cover property (@(posedge clk_i) disable iff (rst_i) link.hit ##2 mgmt_interrupt_out_o);
  c_clear_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_stat_r ##1 clr_wake ##1 !wake_stat_r);
  c_read_stat: cover property (@(posedge clk_i) disable iff (rst_i) req && !wb_we_i && wb_adr_i == MPWD_OFS_STAT);

endmodule : mpwd_top

// [inc/mpwd_if.sv]
// carrier between register file and pattern matcher
`timescale 1ns/1ps
interface mpwd_if;
  import mpwd_pkg::*;
  logic enable;
  mpwd_byte_t addr [MPWD_FIELD_LEN];
  mpwd_byte_t pwd [MPWD_FIELD_LEN];
  logic frame;
  logic valid;
  mpwd_byte_t data;
  logic hit;

  modport regs (output enable, output addr, output pwd, output frame, output valid, output data, input hit);
  modport match (input enable, input addr, input pwd, input frame, input valid, input data, output hit);
endinterface : mpwd_if

// [inc/mpwd_pkg.sv]
// constants and types for the magic packet wake detector
package mpwd_pkg;

  // ------------------------------------------------------------
  // register byte offsets on the wishbone bus
  // ------------------------------------------------------------
  localparam logic [7:0] MPWD_OFS_CTRL = 8'h00;
  localparam logic [7:0] MPWD_OFS_MASK = 8'h04;
  localparam logic [7:0] MPWD_OFS_STAT = 8'h08;
  localparam logic [7:0] MPWD_OFS_ADDR0 = 8'h10;
  localparam logic [7:0] MPWD_OFS_PWD0 = 8'h28;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int MPWD_BIT_ENABLE = 0;
  localparam int MPWD_BIT_MASK = 0;
  localparam int MPWD_BIT_WAKE = 0;
  localparam logic MPWD_RST_ENABLE = 1'b0;
  localparam logic MPWD_RST_MASK = 1'b0;
  localparam logic MPWD_RST_STAT = 1'b0;
  localparam logic [7:0] MPWD_RST_BYTE = 8'h00;

  // ------------------------------------------------------------
  // packet layout
  // ------------------------------------------------------------
  localparam int MPWD_FIELD_LEN = 6;
  localparam logic [2:0] MPWD_LAST_IDX = 3'h5;
  localparam logic [3:0] MPWD_LAST_REP = 4'hf;
  localparam logic [7:0] MPWD_ONES = 8'hff;

  typedef enum logic [2:0] {
    MPWD_ST_HUNT = 3'b001,
    MPWD_ST_ADDR = 3'b010,
    MPWD_ST_PWD = 3'b100
  } mpwd_state_t;

  typedef logic [7:0] mpwd_byte_t;

endpackage : mpwd_pkg

// [tb/mpwd_host_model.sv]
// host soc model: wishbone master that programs the wake detector
`timescale 1ns/1ps
module mpwd_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // ----------------------------------------------------------
  // single classic cycle, entered just after a rising edge
  // ----------------------------------------------------------
  // host programs registers
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    // request stands until ack is seen; only the bench watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask : bus
endmodule : mpwd_host_model

// [tb/mpwd_tb_top.sv]
// self-checking bench for the magic packet wake detector
`timescale 1ns/1ps
module mpwd_tb_top;
  import mpwd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_frame_i = 1'b0, rx_valid_i = 1'b0;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  mpwd_byte_t rx_data_i = 8'h00;
  logic mgmt_interrupt_out_o;
  logic [31:0] exp_q[$];
  mpwd_byte_t sa[6], pw[6];
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'h0b19;

  always #20 clk_i = ~clk_i;

  mpwd_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_frame_i(rx_frame_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .mgmt_interrupt_out_o(mgmt_interrupt_out_o));

  mpwd_host_model host_u (.clk_i(clk_i), .ack_i(wb_ack_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i),
    .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

  // ----------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (e !== s) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask : cmp

  // read data is taken at the ack edge, oldest note first
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) cmp("wb_dat_o unexpected", 32'hx, wb_dat_o);
      else cmp("wb_dat_o", exp_q.pop_front(), wb_dat_o);
    end
  end

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host_u.bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.bus(1'b1, a, d);
  endtask : wr

  // ----------------------------------------------------------
  // frame source: filler, header, copies, password field
  // ----------------------------------------------------------
  task automatic pkt(input int nh, input int nc, input logic [15:0] bm, input int pm, input int split,
                     input int gmax, input logic ei, input logic es);
    mpwd_byte_t q[$];
    int g;
    repeat (3) q.push_back(mpwd_byte_t'($random(seed)) & 8'h7f);
    repeat (nh) q.push_back(MPWD_ONES);
    for (int c = 0; c < nc; c++)
      for (int i = 0; i < 6; i++) q.push_back(bm[c] ? MPWD_ONES : sa[i]);
    for (int i = 0; i < 6; i++)
      q.push_back(pm == 0 ? mpwd_byte_t'($random(seed)) & 8'h7f : (pm == 2 && i == 3) ? pw[i] ^ 8'h01 : pw[i]);
    rx_frame_i <= 1'b1;
    @(posedge clk_i);
    foreach (q[k]) begin
      if (k == split) begin
        rx_valid_i <= 1'b0;
        rx_frame_i <= 1'b0;
        @(posedge clk_i);
        rx_frame_i <= 1'b1;
      end
      g = (gmax == 0) ? 0 : {$random(seed)} % (gmax + 1);
      rx_valid_i <= 1'b1;
      rx_data_i <= q[k];
      @(posedge clk_i);
      if (g != 0) begin
        rx_valid_i <= 1'b0;
        rx_data_i <= ~q[k];
        repeat (g) @(posedge clk_i);
      end
    end
    rx_valid_i <= 1'b0;
    rx_data_i <= 8'ha5;
    rx_frame_i <= 1'b0;
    // irq follows the taking edge of the last byte by two edges
    repeat (4) @(posedge clk_i);
    cmp("mgmt_interrupt_out_o", {31'h0, ei}, {31'h0, mgmt_interrupt_out_o});
    rd(MPWD_OFS_STAT, {31'h0, es});
    if (es) wr(MPWD_OFS_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    cmp("irq after clear", 32'h0, {31'h0, mgmt_interrupt_out_o});
  endtask : pkt

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  initial begin
    #(40 * 60000);
    num_errors++;
    stop_test();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 17; i++) rd(8'(4 * i), 32'h0);
    wr(8'h40, $random(seed));
    rd(8'h40, 32'h0);
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      sa[i] = d[7:0] & 8'h7f;
      pw[i] = (d[15:8] & 8'h7f) | 8'h01;
      wr(MPWD_OFS_ADDR0 + 8'(4 * i), {d[31:8], sa[i]});
      rd(MPWD_OFS_ADDR0 + 8'(4 * i), {24'h0, sa[i]});
    end
    wr(MPWD_OFS_MASK, 32'h1);
    pkt(6, 16, 16'h0, 0, 1000, 0, 1'b0, 1'b0);
    // enable goes after address and mask; the password is written later
    wr(MPWD_OFS_CTRL, 32'h1);
    rd(MPWD_OFS_CTRL, 32'h1);
    pkt(6, 16, 16'h0, 0, 1000, 0, 1'b1, 1'b1);
    // slow spacing stands for a link lowered to ten megabit before sleep
    pkt(6, 16, 16'h8421, 0, 1000, 9, 1'b1, 1'b1);
    pkt(6, 16, 16'h0, 0, 1000, 1, 1'b1, 1'b1);
    pkt(5, 16, 16'h0, 0, 1000, 1, 1'b0, 1'b0);
    pkt(6, 15, 16'h0, 0, 1000, 0, 1'b0, 1'b0);
    pkt(6, 16, 16'h0, 0, 30, 0, 1'b0, 1'b0);
    wr(MPWD_OFS_MASK, 32'h0);
    // masked: status still latches, only the interrupt stays low
    pkt(6, 16, 16'h0, 0, 1000, 0, 1'b0, 1'b1);
    pkt(6, 16, 16'h0, 0, 1000, 0, 1'b0, 1'b1);
    wr(MPWD_OFS_MASK, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(MPWD_OFS_PWD0 + 8'(4 * i), {24'h0, pw[i]});
      rd(MPWD_OFS_PWD0 + 8'(4 * i), {24'h0, pw[i]});
    end
    pkt(6, 16, 16'h0, 1, 1000, 1, 1'b1, 1'b1);
    pkt(6, 16, 16'h0, 2, 1000, 0, 1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    cmp("pending reads", 32'h0, exp_q.size());
    stop_test();
  end
endmodule : mpwd_tb_top
